// File: dcl_dir.sv
// Tag and line-state directory of one core's private level-one data cache.
// Lookup is combinational on lk_addr; a write updates the looked-up set.
`timescale 1ns/100ps
`default_nettype none
module dcl_dir #(
  parameter int SETS = 64,
  parameter int WAYS = 8,
  parameter int OFS_W = 6
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [dcl_pkg::ADDR_W-1:0] lk_addr,
  output logic hit,
  output logic [2:0] hit_way,
  output dcl_pkg::dcl_mesi_t hit_state,
  output logic [2:0] vic_way,
  output logic [dcl_pkg::ADDR_W-1:0] vic_addr,
  output dcl_pkg::dcl_mesi_t vic_state,
  input wire logic wr_en,
  input wire logic [2:0] wr_way,
  input wire dcl_pkg::dcl_mesi_t wr_state
);
  localparam int IDX_W = $clog2(SETS);
  localparam int TAG_W = dcl_pkg::ADDR_W - IDX_W - OFS_W;

  logic [TAG_W-1:0] tag_q [SETS*WAYS];
  logic [TAG_W-1:0] tag_d [SETS*WAYS];
  dcl_pkg::dcl_mesi_t st_q [SETS*WAYS];
  dcl_pkg::dcl_mesi_t st_d [SETS*WAYS];
  logic [2:0] rr_q [SETS];
  logic [2:0] rr_d [SETS];
  logic [IDX_W-1:0] set;
  logic [TAG_W-1:0] tag;
  logic inv_found;

  assign set = lk_addr[OFS_W +: IDX_W];
  assign tag = lk_addr[dcl_pkg::ADDR_W-1 -: TAG_W];

  // Hit search; victim prefers a free way, else round robin
  always_comb begin
    hit = 1'b0;
    hit_way = 3'h0;
    hit_state = dcl_pkg::DCL_INV;
    inv_found = 1'b0;
    vic_way = rr_q[set];
    for (int w = 0; w < WAYS; w++) begin
      if (st_q[set*WAYS+w] != dcl_pkg::DCL_INV &&
          tag_q[set*WAYS+w] == tag) begin
        hit = 1'b1;
        hit_way = 3'(w);
        hit_state = st_q[set*WAYS+w];
      end
      if (st_q[set*WAYS+w] == dcl_pkg::DCL_INV && !inv_found) begin
        inv_found = 1'b1;
        vic_way = 3'(w);
      end
    end
    vic_state = st_q[set*WAYS+int'(vic_way)];
    vic_addr = {tag_q[set*WAYS+int'(vic_way)], set, {OFS_W{1'b0}}};
  end

  // Next directory contents
  always_comb begin
    tag_d = tag_q;
    st_d = st_q;
    rr_d = rr_q;
    if (wr_en) begin
      tag_d[set*WAYS+int'(wr_way)] = tag;
      st_d[set*WAYS+int'(wr_way)] = wr_state;
      if (wr_way == rr_q[set]) begin
        rr_d[set] = (int'(rr_q[set]) + 1 == WAYS) ? 3'h0 : rr_q[set] + 3'h1;
      end
    end
  end

  // Line states reset to invalid; tags need no reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < SETS*WAYS; i++) begin
        st_q[i] <= dcl_pkg::DCL_INV;
      end
      for (int s = 0; s < SETS; s++) begin
        rr_q[s] <= 3'h0;
      end
    end else begin
      st_q <= st_d;
      rr_q <= rr_d;
    end
  end

  always_ff @(posedge mclk) begin
    tag_q <= tag_d;
  end
endmodule : dcl_dir
`default_nettype wire

// File: dcl_lookup.sv
// Functional notes
// R1: Loads search own L1, then peer L1 with the L2, then memory.
// R2: Peer L1 supplies a line only if modified there, whatever the L2 holds.
// R3: A store first gets its line Exclusive or Modified in its own L1.
// R4: Store ownership searches own L1, then peer L1 with the L2, then memory.
// R5: Once owned, the store writes its own L1 and marks the line modified.
// R6: Store ownership reads and writes follow retirement, in retirement order.
// R7: A displaced modified line is evicted in parallel with its refill.
// R8: Eviction write-back uses the cache path and, to memory, the shared bus.
// R9: Both cores share one L2 and one bus interface; each L1 stays private.
// R10: Loads predicted independent of older stores read L1 without waiting; the code holds one while its core already tracks a speculative load.
// R11: Predictions are checked; a conflict replays the load and all younger.
// R12: Each L1: 32 KB, 8-way, 64-byte lines, write-back; L2 lines 64 bytes.
//
// Cache lookup and ownership sequencer for two cores with private L1s.
// Assumes the L2 and bus answer only after their request was taken.
`timescale 1ns/100ps
`default_nettype none
module dcl_lookup #(
  parameter int L1_BYTES = dcl_pkg::L1_BYTES,
  parameter int WAYS = dcl_pkg::L1_WAYS,
  parameter int LINE_BYTES = dcl_pkg::LINE_BYTES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [1:0] req_valid,
  input wire dcl_pkg::dcl_req_t [1:0] req,
  output logic [1:0] req_ready,
  output logic [1:0] rsp_valid,
  output dcl_pkg::dcl_rsp_t rsp,
  input wire logic [1:0] sa_valid,
  input wire dcl_pkg::dcl_staddr_t [1:0] sa,
  input wire logic [1:0] chk_done,
  output logic [1:0] replay_valid,
  output logic [1:0][dcl_pkg::SEQ_W-1:0] replay_seq,
  output logic l2_req_valid,
  output dcl_pkg::dcl_fetch_t l2_req,
  input wire logic l2_req_ready,
  input wire logic l2_rsp_valid,
  input wire logic l2_rsp_hit,
  input wire logic l2_rsp_shared,
  output logic wb_valid,
  output logic [dcl_pkg::ADDR_W-1:0] wb_addr,
  input wire logic wb_ready,
  output logic bus_req_valid,
  output dcl_pkg::dcl_fetch_t bus_req,
  input wire logic bus_req_ready,
  input wire logic bus_rsp_valid
);
  localparam int SETS = L1_BYTES / (LINE_BYTES * WAYS);
  localparam int OFS_W = $clog2(LINE_BYTES);

  // R12
  if (WAYS != 8 || LINE_BYTES != dcl_pkg::L2_LINE_BYTES ||
      SETS < 1 || (SETS & (SETS - 1)) != 0) begin : g_bad_geometry
    $error("dcl_lookup: unsupported cache geometry");
  end

  typedef enum logic [1:0] {DCL_IDLE, DCL_LOOK, DCL_L2, DCL_BUS} dcl_fsm_t;

  // Line address of a byte address
  function automatic logic [dcl_pkg::ADDR_W-1:0] line_of(
    input logic [dcl_pkg::ADDR_W-1:0] a);
    line_of = {a[dcl_pkg::ADDR_W-1:OFS_W], {OFS_W{1'b0}}};
  endfunction : line_of

  // True when sequence number a is older than b, modulo wrap
  function automatic logic older(input logic [dcl_pkg::SEQ_W-1:0] a,
                                 input logic [dcl_pkg::SEQ_W-1:0] b);
    logic [dcl_pkg::SEQ_W-1:0] diff;
    diff = b - a;
    older = (diff != '0) && !diff[dcl_pkg::SEQ_W-1];
  endfunction : older

  dcl_fsm_t st_q, st_d;
  dcl_pkg::dcl_req_t cur_q, cur_d;
  logic core_q, core_d, rr_q, rr_d;
  logic [2:0] tgt_q, tgt_d;
  logic l2p_q, l2p_d, busp_q, busp_d, wbv_q, wbv_d;
  logic [dcl_pkg::ADDR_W-1:0] wba_q, wba_d;
  logic [1:0] rspv_q, rspv_d;
  dcl_pkg::dcl_rsp_t rsp_q, rsp_d;
  logic [1:0] hit, we, elig;
  logic [1:0][2:0] hit_way, vic_way, wway;
  logic [1:0][dcl_pkg::ADDR_W-1:0] vic_addr;
  dcl_pkg::dcl_mesi_t hit_st [2];
  dcl_pkg::dcl_mesi_t vic_st [2];
  dcl_pkg::dcl_mesi_t wst [2];
  logic gnt, own, peer, need_wb, peer_mod;
  logic [1:0] spv_q, spv_d, rpv_q, rpv_d;
  logic [1:0][dcl_pkg::ADDR_W-1:0] spa_q, spa_d;
  logic [1:0][dcl_pkg::SEQ_W-1:0] sps_q, sps_d, rps_q, rps_d;
  logic [1:0][dcl_pkg::PRED_W-1:0] spi_q, spi_d;
  logic [1:0][(1<<dcl_pkg::PRED_W)-1:0] pdep_q, pdep_d;

  // ----------------------------------------------------------------------
  // Private directories, one per core
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_dir // R9
    dcl_dir #(.SETS(SETS), .WAYS(WAYS), .OFS_W(OFS_W)) u_dir (
      .mclk(mclk),
      .rst_b(rst_b),
      .lk_addr(cur_q.addr),
      .hit(hit[c]),
      .hit_way(hit_way[c]),
      .hit_state(hit_st[c]),
      .vic_way(vic_way[c]),
      .vic_addr(vic_addr[c]),
      .vic_state(vic_st[c]),
      .wr_en(we[c]),
      .wr_way(wway[c]),
      .wr_state(wst[c])
    );
  end

  // ----------------------------------------------------------------------
  // Arbitration: one shared path, alternate priority between cores
  // ----------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // Unsure loads wait unless predicted independent and untracked
      elig[c] = req_valid[c] && (req[c].store || !req[c].unres ||
                (!pdep_q[c][req[c].pc_idx] && !spv_q[c])); // R10
    end
    gnt = elig[1] && (!elig[0] || rr_q);
    req_ready[0] = (st_q == DCL_IDLE) && elig[0] && !gnt; // R6 R9
    req_ready[1] = (st_q == DCL_IDLE) && elig[1] && gnt;
  end

  assign own = core_q;
  assign peer = !core_q;
  assign need_wb = !hit[own] && vic_st[own] == dcl_pkg::DCL_MOD;
  assign peer_mod = hit[peer] && hit_st[peer] == dcl_pkg::DCL_MOD;

  // ----------------------------------------------------------------------
  // Transaction sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cur_d = cur_q;
    core_d = core_q;
    rr_d = rr_q;
    tgt_d = tgt_q;
    l2p_d = l2p_q && !l2_req_ready;
    busp_d = busp_q && !bus_req_ready;
    wbv_d = wbv_q && !wb_ready;
    wba_d = wba_q;
    rspv_d = 2'b00;
    rsp_d = rsp_q;
    we = 2'b00;
    wway = '0;
    wst[0] = dcl_pkg::DCL_INV;
    wst[1] = dcl_pkg::DCL_INV;
    rsp_d.store = cur_q.store;
    rsp_d.seq = cur_q.seq;
    case (st_q)
      DCL_IDLE: begin
        if (|(req_ready)) begin
          core_d = gnt;
          cur_d = req[gnt];
          rr_d = !gnt;
          st_d = DCL_LOOK;
        end
      end
      DCL_LOOK: begin
        if (hit[own] && (!cur_q.store || hit_st[own] == dcl_pkg::DCL_EXC ||
            hit_st[own] == dcl_pkg::DCL_MOD)) begin // R1 R3 R4
          we[own] = cur_q.store;
          wway[own] = hit_way[own];
          wst[own] = dcl_pkg::DCL_MOD; // R5
          rsp_d.src = dcl_pkg::DCL_SRC_OWN;
          rsp_d.way = hit_way[own];
          rsp_d.state = cur_q.store ? dcl_pkg::DCL_MOD : hit_st[own];
          rspv_d[own] = 1'b1;
          st_d = DCL_IDLE;
        end else if (!(need_wb && wbv_q)) begin
          // Old write-back still pending: hold rather than lose a victim
          tgt_d = hit[own] ? hit_way[own] : vic_way[own];
          if (need_wb) begin // R7 R8
            wbv_d = 1'b1;
            wba_d = vic_addr[own];
          end
          we[peer] = hit[peer] &&
                     (cur_q.store || hit_st[peer] != dcl_pkg::DCL_SHR);
          wway[peer] = hit_way[peer];
          wst[peer] = cur_q.store ? dcl_pkg::DCL_INV : dcl_pkg::DCL_SHR;
          if (peer_mod) begin // R2
            we[own] = 1'b1;
            wway[own] = tgt_d;
            wst[own] = cur_q.store ? dcl_pkg::DCL_MOD : dcl_pkg::DCL_SHR;
            rsp_d.src = dcl_pkg::DCL_SRC_PEER;
            rsp_d.way = tgt_d;
            rsp_d.state = wst[own];
            rspv_d[own] = 1'b1;
            st_d = DCL_IDLE;
          end else begin // R1 R4
            l2p_d = 1'b1;
            st_d = DCL_L2;
          end
        end
      end
      DCL_L2: begin
        if (l2_rsp_valid && l2_rsp_hit) begin
          we[own] = 1'b1;
          wway[own] = tgt_q;
          wst[own] = cur_q.store ? dcl_pkg::DCL_MOD :
                     (l2_rsp_shared ? dcl_pkg::DCL_SHR : dcl_pkg::DCL_EXC);
          rsp_d.src = dcl_pkg::DCL_SRC_L2;
          rsp_d.way = tgt_q;
          rsp_d.state = wst[own];
          rspv_d[own] = 1'b1;
          st_d = DCL_IDLE;
        end else if (l2_rsp_valid) begin
          busp_d = 1'b1; // R1 R4
          st_d = DCL_BUS;
        end
      end
      DCL_BUS: begin
        if (bus_rsp_valid) begin
          we[own] = 1'b1;
          wway[own] = tgt_q;
          wst[own] = cur_q.store ? dcl_pkg::DCL_MOD : dcl_pkg::DCL_EXC;
          rsp_d.src = dcl_pkg::DCL_SRC_MEM;
          rsp_d.way = tgt_q;
          rsp_d.state = wst[own];
          rspv_d[own] = 1'b1;
          st_d = DCL_IDLE;
        end
      end
      default: st_d = DCL_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= DCL_IDLE;
      cur_q <= '0;
      core_q <= 1'b0;
      rr_q <= 1'b0;
      tgt_q <= 3'h0;
      l2p_q <= 1'b0;
      busp_q <= 1'b0;
      wbv_q <= 1'b0;
      wba_q <= '0;
      rspv_q <= 2'b00;
      rsp_q <= '0;
    end else begin
      st_q <= st_d;
      cur_q <= cur_d;
      core_q <= core_d;
      rr_q <= rr_d;
      tgt_q <= tgt_d;
      l2p_q <= l2p_d;
      busp_q <= busp_d;
      wbv_q <= wbv_d;
      wba_q <= wba_d;
      rspv_q <= rspv_d;
      rsp_q <= rsp_d;
    end
  end

  assign rsp_valid = rspv_q;
  assign rsp = rsp_q;
  assign l2_req_valid = l2p_q;
  assign l2_req = '{rfo: cur_q.store, addr: line_of(cur_q.addr)};
  assign bus_req_valid = busp_q;
  assign bus_req = '{rfo: cur_q.store, addr: line_of(cur_q.addr)};
  assign wb_valid = wbv_q; // R8
  assign wb_addr = wba_q;

  // ----------------------------------------------------------------------
  // Disambiguation: one tracked speculative load per core
  // ----------------------------------------------------------------------
  // Dependence bits only ever set: pessimistic, but never replays twice
  always_comb begin
    spv_d = spv_q;
    spa_d = spa_q;
    sps_d = sps_q;
    spi_d = spi_q;
    pdep_d = pdep_q;
    rpv_d = 2'b00;
    rps_d = rps_q;
    for (int c = 0; c < 2; c++) begin
      if (spv_q[c] && sa_valid[c] && line_of(sa[c].addr) == spa_q[c] &&
          older(sa[c].seq, sps_q[c])) begin // R11
        rpv_d[c] = 1'b1;
        rps_d[c] = sps_q[c];
        pdep_d[c][spi_q[c]] = 1'b1;
        spv_d[c] = 1'b0;
      end else if (chk_done[c]) begin
        spv_d[c] = 1'b0;
      end
      if (req_ready[c] && !req[c].store && req[c].unres) begin // R10
        spv_d[c] = 1'b1;
        spa_d[c] = line_of(req[c].addr);
        sps_d[c] = req[c].seq;
        spi_d[c] = req[c].pc_idx;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      spv_q <= 2'b00;
      spa_q <= '0;
      sps_q <= '0;
      spi_q <= '0;
      pdep_q <= '0;
      rpv_q <= 2'b00;
      rps_q <= '0;
    end else begin
      spv_q <= spv_d;
      spa_q <= spa_d;
      sps_q <= sps_d;
      spi_q <= spi_d;
      pdep_q <= pdep_d;
      rpv_q <= rpv_d;
      rps_q <= rps_d;
    end
  end

  assign replay_valid = rpv_q;
  assign replay_seq = rps_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence look_own_load_s;
    st_q == DCL_LOOK && !cur_q.store && hit[own];
  endsequence

  own_first_a: assert property (look_own_load_s |=> // R1
    rsp_valid != 2'b00 && rsp.src == dcl_pkg::DCL_SRC_OWN)
    else $error("own-cache load hit not answered from own cache");
  peer_mod_only_a: assert property ( // R2
    rsp_valid != 2'b00 && rsp.src == dcl_pkg::DCL_SRC_PEER |->
    $past(peer_mod)) else $error("peer line taken while not modified");
  store_owned_a: assert property (rsp_valid != 2'b00 && rsp.store |-> // R3
    rsp.state == dcl_pkg::DCL_MOD)
    else $error("store answered without ownership");
  fetch_order_a: assert property ($rose(l2_req_valid) |-> // R4
    $past(st_q) == DCL_LOOK && !$past(peer_mod))
    else $error("L2 fetched before own and peer caches searched");
  store_marks_a: assert property ( // R5
    st_q != DCL_IDLE && cur_q.store && we[own] |->
    wst[own] == dcl_pkg::DCL_MOD)
    else $error("store write does not mark line modified");
  one_inflight_a: assert property (st_q != DCL_IDLE |-> // R6
    req_ready == 2'b00) else $error("second request taken while busy");
  evict_parallel_a: assert property ($rose(wb_valid) |-> // R7
    (l2_req_valid && $rose(l2_req_valid)) || $past(peer_mod))
    else $error("eviction not paired with its fill");
  wb_hold_a: assert property (wb_valid && !wb_ready |=> // R8
    wb_valid && $stable(wb_addr)) else $error("write-back dropped");
  shared_path_a: assert property (l2_req_valid |-> !bus_req_valid) // R9
    else $error("L2 and bus requested together");

  for (genvar c = 0; c < 2; c++) begin : g_chk
    pred_wait_a: assert property ( // R10
      req_valid[c] && req[c].unres && !req[c].store &&
      pdep_q[c][req[c].pc_idx] |-> !req_ready[c])
      else $error("predicted-dependent load issued early");
    replay_a: assert property ( // R11
      spv_q[c] && sa_valid[c] && line_of(sa[c].addr) == spa_q[c] &&
      older(sa[c].seq, sps_q[c]) |=> replay_valid[c] &&
      replay_seq[c] == $past(sps_q[c]))
      else $error("conflict not replayed");
  end
endmodule : dcl_lookup
`default_nettype wire

// File: dcl_mem_model.sv
// Memory-side responder: L2 port, write-back port and bus port.
// Assumes the lookup block holds each valid level until ready.
`timescale 1ns/100ps
`default_nettype none
module dcl_mem_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hit_en,
  input wire logic shared_en,
  input wire logic slow,
  input wire logic l2_req_valid,
  output logic l2_req_ready,
  output logic l2_rsp_valid,
  output logic l2_rsp_hit,
  output logic l2_rsp_shared,
  input wire logic wb_valid,
  output logic wb_ready,
  input wire logic bus_req_valid,
  output logic bus_req_ready,
  output logic bus_rsp_valid
);
  logic [2:0] lat, l2_w, bus_w, wb_w;
  logic l2_busy, bus_busy;
  assign lat = slow ? 3'h4 : 3'h0;
  // Accept after lat cycles, answer lat cycles after the accept.
  // Idle hit flags toggle so a stale sample is never trusted.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {l2_req_ready, l2_rsp_valid, l2_rsp_hit, l2_rsp_shared} <= 4'h0;
      {wb_ready, bus_req_ready, bus_rsp_valid} <= 3'h0;
      {l2_busy, bus_busy, l2_w, bus_w, wb_w} <= 11'h0;
    end else begin
      {l2_req_ready, l2_rsp_valid, wb_ready} <= 3'h0;
      {bus_req_ready, bus_rsp_valid} <= 2'h0;
      l2_rsp_hit <= ~l2_rsp_hit;
      l2_rsp_shared <= ~l2_rsp_shared;
      if (l2_busy) begin
        l2_w <= l2_w + 3'h1;
        if (l2_w == lat) begin
          {l2_rsp_valid, l2_busy, l2_w} <= {2'b10, 3'h0};
          l2_rsp_hit <= hit_en;
          l2_rsp_shared <= shared_en;
        end
      end else if (l2_req_valid && !l2_req_ready) begin
        l2_w <= l2_w + 3'h1;
        if (l2_w == lat) {l2_req_ready, l2_busy, l2_w} <= {2'b11, 3'h0};
      end
      if (bus_busy) begin
        bus_w <= bus_w + 3'h1;
        if (bus_w == lat) {bus_rsp_valid, bus_busy, bus_w} <= {2'b10, 3'h0};
      end else if (bus_req_valid && !bus_req_ready) begin
        bus_w <= bus_w + 3'h1;
        if (bus_w == lat) {bus_req_ready, bus_busy, bus_w} <= {2'b11, 3'h0};
      end
      if (wb_valid && !wb_ready) begin
        wb_w <= wb_w + 3'h1;
        if (wb_w == lat) {wb_ready, wb_w} <= {1'b1, 3'h0};
      end
    end
  end
endmodule : dcl_mem_model
`default_nettype wire

// File: dcl_pkg.sv
// Shared constants and carrier types for the dual-core cache lookup block.
// Assumes one core clock domain; addresses are byte addresses.
package dcl_pkg;

  // ----------------------------------------------------------------------
  // Geometry and widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int L1_BYTES = 32768;
  localparam int L1_WAYS = 8;
  localparam int LINE_BYTES = 64;
  localparam int L2_LINE_BYTES = 64;
  localparam int PRED_W = 4;
  localparam int SEQ_W = 8;
  localparam int NCORE = 2;

  // ----------------------------------------------------------------------
  // Enumerations and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {DCL_INV, DCL_SHR, DCL_EXC, DCL_MOD} dcl_mesi_t;
  typedef enum logic [1:0] {
    DCL_SRC_OWN, DCL_SRC_PEER, DCL_SRC_L2, DCL_SRC_MEM
  } dcl_src_t;

  // Request from a core: loads at execute, stores after retirement
  typedef struct packed {
    logic store;
    logic unres;
    logic [ADDR_W-1:0] addr;
    logic [PRED_W-1:0] pc_idx;
    logic [SEQ_W-1:0] seq;
  } dcl_req_t;

  typedef struct packed {
    dcl_src_t src;
    dcl_mesi_t state;
    logic [2:0] way;
    logic store;
    logic [SEQ_W-1:0] seq;
  } dcl_rsp_t;

  typedef struct packed {
    logic rfo;
    logic [ADDR_W-1:0] addr;
  } dcl_fetch_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [SEQ_W-1:0] seq;
  } dcl_staddr_t;

endpackage : dcl_pkg

// File: tb_dual_core_shared_cache_lookup.sv
// Self-checking bench for the dual-core cache lookup block.
// Assumes dcl_pkg, dcl_lookup and dcl_mem_model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_dual_core_shared_cache_lookup;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [31:0] LINE_A = 32'h0000_1040;
  localparam logic [31:0] LINE_B = 32'h0002_0080;
  logic mclk, rst_b, l2_req_valid, l2_req_ready, l2_rsp_valid;
  logic [1:0] req_valid, req_ready, rsp_valid, sa_valid, chk_done;
  logic [1:0] replay_valid;
  logic [1:0][7:0] replay_seq;
  dcl_pkg::dcl_req_t [1:0] req;
  dcl_pkg::dcl_rsp_t rsp, got;
  dcl_pkg::dcl_staddr_t [1:0] sa;
  dcl_pkg::dcl_fetch_t l2_req, bus_req, l2_seen, bus_seen;
  logic l2_rsp_hit, l2_rsp_shared, wb_valid, wb_ready, bus_req_valid;
  logic bus_req_ready, bus_rsp_valid, hit_en, shared_en, slow;
  logic l2_prev, wb_with_fill;
  logic [31:0] wb_addr, wb_seen;
  int error_cnt, num_checks, lat, wait_n, l2_cnt, bus_cnt, wb_cnt, cyc;

  dcl_lookup DUT (
    .mclk, .rst_b, .req_valid, .req, .req_ready, .rsp_valid, .rsp,
    .sa_valid, .sa, .chk_done, .replay_valid, .replay_seq,
    .l2_req_valid, .l2_req, .l2_req_ready, .l2_rsp_valid, .l2_rsp_hit,
    .l2_rsp_shared, .wb_valid, .wb_addr, .wb_ready, .bus_req_valid,
    .bus_req, .bus_req_ready, .bus_rsp_valid
  );
  dcl_mem_model mem (
    .mclk, .rst_b, .hit_en, .shared_en, .slow, .l2_req_valid,
    .l2_req_ready, .l2_rsp_valid, .l2_rsp_hit, .l2_rsp_shared,
    .wb_valid, .wb_ready, .bus_req_valid, .bus_req_ready, .bus_rsp_valid
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Log port traffic at the falling edge, where registered outputs settled
  always @(negedge mclk) begin
    if (l2_req_valid && l2_req_ready) begin
      l2_seen = l2_req;
      l2_cnt++;
    end
    if (bus_req_valid && bus_req_ready) begin
      bus_seen = bus_req;
      bus_cnt++;
    end
    if (wb_valid && wb_ready) begin
      wb_seen = wb_addr;
      wb_cnt++;
    end
    if (l2_req_valid && !l2_prev) wb_with_fill = wb_valid;
    l2_prev = l2_req_valid;
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One request, held until taken; waits for its response pulse
  task automatic send(input int c, input logic st, input logic un,
      input logic [31:0] a, input logic [3:0] pc, input logic [7:0] sq);
    @(negedge mclk);
    req_valid[c] = 1'b1;
    req[c] = '{store: st, unres: un, addr: a, pc_idx: pc, seq: sq};
    wait_n = 0;
    #1;
    while (req_ready[c] !== 1'b1 && wait_n < 200) begin
      @(negedge mclk);
      #1 wait_n++;
    end
    @(negedge mclk);
    req_valid[c] = 1'b0;
    req[c] = ~req[c];
    lat = 1;
    while (rsp_valid[c] !== 1'b1 && lat < 300) begin
      @(negedge mclk);
      lat++;
    end
    got = rsp;
    check("rsp_valid", rsp_valid[c], 1);
  endtask : send

  task automatic expect_rsp(input string nm, input dcl_pkg::dcl_src_t s,
      input dcl_pkg::dcl_mesi_t m, input logic [7:0] sq);
    check({nm, " src"}, got.src, s);
    check({nm, " state"}, got.state, m);
    check({nm, " seq"}, got.seq, sq);
  endtask : expect_rsp

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_search;
    int b0;
    int l0;
    b0 = bus_cnt;
    {hit_en, shared_en, slow} = 3'b000;
    send(0, 1'b0, 1'b0, LINE_A, 4'h0, 8'h01);
    expect_rsp("mem load", dcl_pkg::DCL_SRC_MEM,
               dcl_pkg::DCL_EXC, 8'h01);
    check("fill way", got.way, 0);
    check("bus fetch", bus_cnt - b0, 1);
    check("load rfo", {l2_seen.rfo, bus_seen.rfo}, 0);
    check("bus addr", bus_seen.addr, LINE_A);
    l0 = l2_cnt;
    send(0, 1'b0, 1'b0, LINE_A, 4'h0, 8'h02);
    expect_rsp("own hit", dcl_pkg::DCL_SRC_OWN, dcl_pkg::DCL_EXC, 8'h02);
    check("own hit lat", lat, 2);
    check("own hit fill", l2_cnt - l0, 0);
    $display("test search done");
  endtask : t_search

  // Core 1 takes the line; then core 0 reads it from the modified peer
  task automatic t_peer;
    int l0;
    hit_en = 1'b1;
    send(1, 1'b1, 1'b0, LINE_A, 4'h0, 8'h03);
    expect_rsp("store l2", dcl_pkg::DCL_SRC_L2,
               dcl_pkg::DCL_MOD, 8'h03);
    check("store rfo", l2_seen.rfo, 1);
    l0 = l2_cnt;
    send(0, 1'b0, 1'b0, LINE_A, 4'h0, 8'h04);
    expect_rsp("peer", dcl_pkg::DCL_SRC_PEER, dcl_pkg::DCL_SHR, 8'h04);
    check("peer lat", lat, 2);
    check("peer no l2", l2_cnt - l0, 0);
    $display("test peer done");
  endtask : t_peer

  // Shared own copy must be upgraded before the store lands
  task automatic t_store;
    {shared_en, slow} = 2'b11;
    send(0, 1'b1, 1'b0, LINE_A, 4'h0, 8'h05);
    expect_rsp("upgrade", dcl_pkg::DCL_SRC_L2,
               dcl_pkg::DCL_MOD, 8'h05);
    check("upgrade rfo", l2_seen.rfo, 1);
    {shared_en, slow} = 2'b00;
    send(0, 1'b1, 1'b0, LINE_A, 4'h0, 8'h06);
    expect_rsp("own store", dcl_pkg::DCL_SRC_OWN,
               dcl_pkg::DCL_MOD, 8'h06);
    check("own store lat", lat, 2);
    check("store flag", got.store, 1);
    $display("test store done");
  endtask : t_store

  // Ninth modified line in one set forces a dirty victim
  task automatic t_evict;
    int lat7;
    int w0;
    for (int k = 1; k <= 8; k++) begin
      lat7 = lat;
      w0 = wb_cnt;
      send(0, 1'b1, 1'b0, LINE_A + 32'h1000 * k, 4'h0, 8'h10 + 8'(k));
    end
    check("evict lat", lat, lat7);
    check("evict way", got.way, 0);
    check("evict with fill", wb_with_fill, 1);
    check("wb count", wb_cnt - w0, 1);
    check("wb set", wb_seen[11:6], LINE_A[11:6]);
    check("wb tag", wb_seen[31:12] >= 1 && wb_seen[31:12] <= 8, 1);
    $display("test evict done");
  endtask : t_evict

  task automatic t_disamb;
    logic seen;
    shared_en = 1'b1;
    send(0, 1'b0, 1'b1, LINE_B, 4'h3, 8'h40);
    expect_rsp("shared", dcl_pkg::DCL_SRC_L2, dcl_pkg::DCL_SHR, 8'h40);
    check("unres wait", wait_n, 0);
    @(negedge mclk);
    sa_valid[0] = 1'b1;
    sa[0] = '{addr: LINE_B + 32'h8, seq: 8'h3c};
    @(negedge mclk);
    sa_valid[0] = 1'b0;
    sa[0] = ~sa[0];
    seen = 1'b0;
    repeat (2) begin
      if (replay_valid[0] === 1'b1 && !seen) begin
        seen = 1'b1;
        check("replay seq", replay_seq[0], 8'h40);
      end
      @(negedge mclk);
    end
    check("replay", seen, 1);
    req_valid[0] = 1'b1;
    req[0] = '{store: 1'b0, unres: 1'b1, addr: LINE_B, pc_idx: 4'h3,
               seq: 8'h41};
    seen = 1'b0;
    repeat (6) begin
      #1 seen |= (req_ready[0] !== 1'b0);
      @(negedge mclk);
    end
    req_valid[0] = 1'b0;
    check("sticky refuse", seen, 0);
    send(0, 1'b0, 1'b1, LINE_B, 4'h5, 8'h50);
    check("fresh wait", wait_n, 0);
    chk_done[0] = 1'b1;
    @(negedge mclk);
    chk_done[0] = 1'b0;
    sa_valid[0] = 1'b1;
    sa[0] = '{addr: LINE_B, seq: 8'h4c};
    @(negedge mclk);
    sa_valid[0] = 1'b0;
    seen = 1'b0;
    repeat (3) begin
      seen |= (replay_valid[0] !== 1'b0);
      @(negedge mclk);
    end
    check("no replay", seen, 0);
    $display("test disamb done");
  endtask : t_disamb

  initial begin
    rst_b = 1'b0;
    req_valid = 2'h0;
    req = '0;
    sa_valid = 2'h0;
    sa = '0;
    chk_done = 2'h0;
    {hit_en, shared_en, slow, l2_prev, wb_with_fill} = 5'h0;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    t_search();
    t_peer();
    t_store();
    t_evict();
    t_disamb();
    end_of_test();
  end
endmodule : tb_dual_core_shared_cache_lookup
`default_nettype wire
